// file: hdl/i2c_cfg_pkg.sv
package i2c_cfg_pkg;

  // bus identity and memory shape
  localparam logic [6:0] TARGET_BUS_ID = 7'h69;
  localparam int         MEM_DEPTH     = 256;
  localparam logic [7:0] MEM_DEFAULT   = 8'h00;
  localparam logic       RW_READ       = 1'b1;
  localparam logic       RW_WRITE      = 1'b0;

  // serial clock timing on the 200 MHz host clock
  localparam int CLK_PERIOD_NS = 5;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int SCL_LOW_NS    = 1300;
  localparam int SCL_HIGH_NS   = SCL_PERIOD_NS - SCL_LOW_NS;
  localparam int SCL_LOW_CYC   = (SCL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCL_HIGH_CYC  = (SCL_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    op_write    = 2'b00,
    op_rd_rand  = 2'b01,
    op_rd_cur   = 2'b10
  } op_e;

endpackage

// file: hdl/i2c_link_if.sv
`timescale 1ns/1ps
interface i2c_link_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic t_sda_o;
  logic t_sda_oe;
  logic scl;
  logic sda;

  // open-drain wires with pull-up
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (t_sda_oe & ~t_sda_o));

  modport master (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe,
                  input scl, input sda);
  modport target (output t_sda_o, output t_sda_oe, input scl, input sda);
endinterface

// file: hdl/i2c_cfg_master.sv
`timescale 1ns/1ps
module i2c_cfg_master
  import i2c_cfg_pkg::*;
#(
  parameter logic [6:0] BUS_ID   = TARGET_BUS_ID,
  parameter int         LOW_CYC  = SCL_LOW_CYC,
  parameter int         HIGH_CYC = SCL_HIGH_CYC
)(
  input  wire logic       clk,
  input  wire logic       nrst,
  i2c_link_if.master      link,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire op_e        cmd_op,
  input  wire logic [7:0] cmd_reg,
  input  wire logic [3:0] cmd_len_m1,
  input  wire logic [7:0] wdata,
  output logic            wdata_take,
  output logic            rsp_valid,
  output logic      [7:0] rsp_data,
  output logic            done,
  output logic            nack
);

  typedef enum logic [3:0] {
    h_idle     = 4'b0000,
    h_start1   = 4'b0001,
    h_start2   = 4'b0010,
    h_bit_low  = 4'b0011,
    h_bit_high = 4'b0100,
    h_rstart   = 4'b0101,
    h_stop1    = 4'b0110,
    h_stop2    = 4'b0111,
    h_stop3    = 4'b1000
  } phase_e;

  typedef enum logic [2:0] {
    k_addr_w = 3'b000,
    k_reg    = 3'b001,
    k_wdata  = 3'b010,
    k_addr_r = 3'b011,
    k_rdata  = 3'b100
  } kind_e;

  typedef struct packed {
    logic       sda_s1;
    logic       sda_s2;
    phase_e     phase;
    logic [9:0] timer;
    logic [3:0] bitcnt;
    logic [8:0] shreg;
    kind_e      kind;
    op_e        op;
    logic [7:0] regb;
    logic [3:0] left;
    logic       scl_low;
    logic       sda_low;
    logic       take;
    logic       rsp_valid;
    logic [7:0] rsp_data;
    logic       done;
    logic       nack;
  } master_s;

  master_s s;
  master_s next_s;
  logic    low_end;
  logic    high_end;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    next_s.sda_s1 = link.sda;
    next_s.sda_s2 = s.sda_s1;
    next_s.take = 1'b0;
    next_s.rsp_valid = 1'b0;
    next_s.done = 1'b0;
    next_s.timer = s.timer + 10'h001;
    low_end = (s.timer == 10'(LOW_CYC - 1)); // [RULE2]
    high_end = (s.timer == 10'(HIGH_CYC - 1));
    unique case (s.phase)
      h_idle: begin
        next_s.timer = 10'h000;
        next_s.scl_low = 1'b0;
        next_s.sda_low = 1'b0;
        if (cmd_valid) begin
          next_s.op = cmd_op;
          next_s.regb = cmd_reg;
          next_s.left = cmd_len_m1;
          next_s.nack = 1'b0;
          next_s.bitcnt = 4'h0;
          next_s.phase = h_start1;
          if (cmd_op == op_rd_cur) begin
            next_s.kind = k_addr_r;
            next_s.shreg = {BUS_ID, RW_READ, 1'b1}; // [RULE10]
          end else begin
            next_s.kind = k_addr_w;
            next_s.shreg = {BUS_ID, RW_WRITE, 1'b1}; // [RULE6]
          end
        end
      end
      h_rstart: begin
        if (low_end) begin
          next_s.scl_low = 1'b0;
          next_s.timer = 10'h000;
          next_s.phase = h_start1;
        end
      end
      h_start1: begin
        if (high_end) begin
          next_s.sda_low = 1'b1; // [RULE4]
          next_s.timer = 10'h000;
          next_s.phase = h_start2;
        end
      end
      h_start2: begin
        if (high_end) begin
          next_s.scl_low = 1'b1;
          next_s.timer = 10'h000;
          next_s.phase = h_bit_low;
        end
      end
      h_bit_low: begin
        if (s.timer == 10'(LOW_CYC / 2)) begin
          next_s.sda_low = ~s.shreg[8]; // [RULE3]
        end
        if (low_end) begin
          next_s.scl_low = 1'b0;
          next_s.timer = 10'h000;
          next_s.phase = h_bit_high;
        end
      end
      h_bit_high: begin
        if (s.timer == 10'(HIGH_CYC / 2)) begin
          next_s.shreg = {s.shreg[7:0], s.sda_s2};
          next_s.bitcnt = s.bitcnt + 4'h1;
        end
        if (high_end) begin
          next_s.scl_low = 1'b1;
          next_s.timer = 10'h000;
          next_s.phase = h_bit_low;
          if (s.bitcnt == 4'h9) begin
            next_s.bitcnt = 4'h0;
            next_s.sda_low = 1'b0;
            if (s.kind != k_rdata && s.shreg[0]) begin
              next_s.nack = 1'b1;
              next_s.phase = h_stop1;
            end else begin
              unique case (s.kind)
                k_addr_w: begin
                  next_s.kind = k_reg;
                  next_s.shreg = {s.regb, 1'b1}; // [RULE6]
                end
                k_reg: begin
                  if (s.op == op_write) begin
                    next_s.kind = k_wdata;
                    next_s.shreg = {wdata, 1'b1}; // [RULE8]
                    next_s.take = 1'b1;
                  end else begin
                    next_s.kind = k_addr_r;
                    next_s.shreg = {BUS_ID, RW_READ, 1'b1}; // [RULE13]
                    next_s.phase = h_rstart;
                  end
                end
                k_wdata: begin
                  if (s.left != 4'h0) begin
                    next_s.left = s.left - 4'h1;
                    next_s.shreg = {wdata, 1'b1}; // [RULE9]
                    next_s.take = 1'b1;
                  end else begin
                    next_s.phase = h_stop1;
                  end
                end
                k_addr_r: begin
                  next_s.kind = k_rdata;
                  next_s.shreg = {8'hff, s.left == 4'h0};
                end
                k_rdata: begin
                  next_s.rsp_valid = 1'b1;
                  next_s.rsp_data = s.shreg[8:1];
                  if (s.left != 4'h0) begin
                    next_s.left = s.left - 4'h1;
                    next_s.shreg = {8'hff, s.left == 4'h1}; // [RULE14]
                  end else begin
                    next_s.phase = h_stop1; // [RULE12]
                  end
                end
                default: next_s.phase = h_stop1;
              endcase
            end
          end
        end
      end
      h_stop1: begin
        if (s.timer == 10'(LOW_CYC / 2)) begin
          next_s.sda_low = 1'b1;
        end
        if (low_end) begin
          next_s.scl_low = 1'b0;
          next_s.timer = 10'h000;
          next_s.phase = h_stop2;
        end
      end
      h_stop2: begin
        if (high_end) begin
          next_s.sda_low = 1'b0; // [RULE5]
          next_s.timer = 10'h000;
          next_s.phase = h_stop3;
        end
      end
      h_stop3: begin
        if (low_end) begin
          next_s.done = 1'b1;
          next_s.phase = h_idle;
        end
      end
      default: next_s.phase = h_idle;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign link.m_scl_o = 1'b0;
  assign link.m_scl_oe = s.scl_low;
  assign link.m_sda_o = 1'b0;
  assign link.m_sda_oe = s.sda_low;
  assign cmd_ready = (s.phase == h_idle);
  assign wdata_take = s.take;
  assign rsp_valid = s.rsp_valid;
  assign rsp_data = s.rsp_data;
  assign done = s.done;
  assign nack = s.nack;

endmodule

// file: hdl/i2c_cfg_target.sv
`timescale 1ns/1ps
// Summary of operation
// [RULE1] answer only bus address 69h, rw in lsb
// [RULE2] both directions up to 400 kbit/s
// [RULE3] data changes only while clock low
// [RULE4] data falling with clock high starts frame
// [RULE5] data rising with clock high ends frame
// [RULE6] master sends address, register, then data
// [RULE7] acknowledge each written byte on ninth clock
// [RULE8] single write: address, register, data, stop
// [RULE9] further bytes stored at incrementing address
// [RULE10] read uses address byte with rw one
// [RULE11] pointer holds last accessed location plus one
// [RULE12] read without master acknowledge stops sending
// [RULE13] repeated start loads pointer, stores nothing
// [RULE14] master acknowledge sends next location byte
// [RULE15] pointer wraps from ffh to 00h
// [RULE16] memory takes defaults at reset
// [RULE17] foreign address frames leave data released
module i2c_cfg_target
  import i2c_cfg_pkg::*;
#(
  parameter logic [6:0] BUS_ID = TARGET_BUS_ID
)(
  input  wire logic       link_clk,
  input  wire logic       nrst,
  i2c_link_if.target      link,
  input  wire logic [7:0] cfg_addr,
  output logic      [7:0] cfg_data,
  output logic            busy
);

  typedef enum logic [2:0] {
    t_idle    = 3'b000,
    t_addr    = 3'b001,
    t_addr_ack = 3'b010,
    t_rx      = 3'b011,
    t_rx_ack  = 3'b100,
    t_tx      = 3'b101,
    t_tx_ack  = 3'b110,
    t_ignore  = 3'b111
  } tgt_phase_e;

  typedef struct packed {
    logic       scl_s1;
    logic       scl_s2;
    logic       scl_d;
    logic       sda_s1;
    logic       sda_s2;
    logic       sda_d;
    tgt_phase_e phase;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] register_pointer_byte;
    logic       rw;
    logic       first;
    logic       m_ack;
    logic       drive;
    logic [7:0] cfg_data;
  } target_s;

  target_s    s;
  target_s    next_s;
  logic [7:0] mem [MEM_DEPTH];
  logic       mem_we;
  logic [7:0] mem_wa;
  logic [7:0] mem_wd;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;
  logic [6:0] target_bus_id_field;
  logic [7:0] ptr_next;

  ////////////////////////////////////////////////////////////////////////////
  // bus events from the synchronised pins
  assign scl_rise = s.scl_s2 & ~s.scl_d;
  assign scl_fall = ~s.scl_s2 & s.scl_d;
  assign start_seen = s.scl_s2 & s.scl_d & s.sda_d & ~s.sda_s2; // [RULE4]
  assign stop_seen = s.scl_s2 & s.scl_d & ~s.sda_d & s.sda_s2; // [RULE5]
  assign target_bus_id_field = s.shreg[7:1];
  assign ptr_next = s.register_pointer_byte + 8'h01; // [RULE15]

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    mem_we = 1'b0;
    mem_wa = s.register_pointer_byte;
    mem_wd = s.shreg;
    next_s.scl_s1 = link.scl;
    next_s.scl_s2 = s.scl_s1;
    next_s.scl_d = s.scl_s2;
    next_s.sda_s1 = link.sda;
    next_s.sda_s2 = s.sda_s1;
    next_s.sda_d = s.sda_s2;
    next_s.cfg_data = mem[cfg_addr];
    if (start_seen) begin
      // a repeated start also ends a write before data is stored
      next_s.phase = t_addr; // [RULE13]
      next_s.bitcnt = 4'h0;
      next_s.drive = 1'b0;
    end else if (stop_seen) begin
      next_s.phase = t_idle;
      next_s.drive = 1'b0;
    end else begin
      unique case (s.phase)
        t_idle: begin
          next_s.drive = 1'b0;
        end
        t_ignore: begin
          next_s.drive = 1'b0; // [RULE17]
        end
        t_addr: begin
          if (scl_rise) begin
            next_s.shreg = {s.shreg[6:0], s.sda_s2};
            next_s.bitcnt = s.bitcnt + 4'h1;
          end
          if (scl_fall && s.bitcnt == 4'h8) begin
            if (target_bus_id_field == BUS_ID) begin // [RULE1]
              next_s.rw = s.shreg[0];
              next_s.drive = 1'b1;
              next_s.phase = t_addr_ack;
            end else begin
              next_s.phase = t_ignore; // [RULE17]
            end
          end
        end
        t_addr_ack: begin
          if (scl_fall) begin
            next_s.bitcnt = 4'h0;
            if (s.rw == RW_READ) begin
              // current-address read starts at the pointer
              next_s.shreg = mem[s.register_pointer_byte]; // [RULE11]
              next_s.register_pointer_byte = ptr_next; // [RULE11]
              next_s.drive = ~mem[s.register_pointer_byte][7];
              next_s.phase = t_tx;
            end else begin
              next_s.drive = 1'b0;
              next_s.first = 1'b1;
              next_s.phase = t_rx;
            end
          end
        end
        t_rx: begin
          if (scl_rise) begin
            next_s.shreg = {s.shreg[6:0], s.sda_s2};
            next_s.bitcnt = s.bitcnt + 4'h1;
          end
          if (scl_fall && s.bitcnt == 4'h8) begin
            next_s.drive = 1'b1; // [RULE7]
            next_s.phase = t_rx_ack;
            if (s.first) begin
              next_s.first = 1'b0;
              next_s.register_pointer_byte = s.shreg; // [RULE13]
            end else begin
              mem_we = 1'b1; // [RULE8]
              next_s.register_pointer_byte = ptr_next; // [RULE9]
            end
          end
        end
        t_rx_ack: begin
          if (scl_fall) begin
            next_s.drive = 1'b0;
            next_s.bitcnt = 4'h0;
            next_s.phase = t_rx;
          end
        end
        t_tx: begin
          if (scl_fall) begin
            next_s.bitcnt = s.bitcnt + 4'h1;
            if (s.bitcnt == 4'h7) begin
              next_s.drive = 1'b0;
              next_s.phase = t_tx_ack;
            end else begin
              next_s.shreg = {s.shreg[6:0], 1'b0};
              next_s.drive = ~s.shreg[6]; // [RULE3]
            end
          end
        end
        t_tx_ack: begin
          if (scl_rise) begin
            next_s.m_ack = ~s.sda_s2;
          end
          if (scl_fall) begin
            next_s.bitcnt = 4'h0;
            if (s.m_ack) begin
              next_s.shreg = mem[s.register_pointer_byte]; // [RULE14]
              next_s.register_pointer_byte = ptr_next; // [RULE15]
              next_s.drive = ~mem[s.register_pointer_byte][7];
              next_s.phase = t_tx;
            end else begin
              next_s.drive = 1'b0; // [RULE12]
              next_s.phase = t_ignore;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge link_clk) begin
    if (!nrst) begin
      // pin samples reset to the idle-high bus level, so no false edge follows reset
      s <= {6'h3f, 35'h0};
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration memory
  always_ff @(posedge link_clk) begin
    if (!nrst) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem[i] <= MEM_DEFAULT; // [RULE16]
      end
    end else if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sampling at the link clock keeps pace with a 400 kbit/s bus
  assign link.t_sda_o = 1'b0; // [RULE2]
  assign link.t_sda_oe = s.drive;
  assign cfg_data = s.cfg_data;
  assign busy = (s.phase != t_idle) && (s.phase != t_ignore);

endmodule

// file: tb/i2c_cfg_link_asserts.sv
`timescale 1ns/1ps
module i2c_cfg_link_asserts
  import i2c_cfg_pkg::*;
#(
  parameter logic [6:0] BUS_ID  = TARGET_BUS_ID,
  parameter int         LOW_CYC = SCL_LOW_CYC
)(
  input wire logic clk,
  input wire logic link_clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda,
  input wire logic t_sda_oe
);
  logic        scl_q;
  logic        sda_q;
  logic        wr_frame;
  logic        addr_done;
  logic [3:0]  bitn;
  logic [7:0]  shreg;
  logic [15:0] lo_cnt;
  logic        start_ev;
  logic        stop_ev;
  logic        rise_ev;
  logic        ninth;

  ////////////////////////////////////////
  // bus event tracking
  assign start_ev = scl & scl_q & sda_q & ~sda;
  assign stop_ev  = scl & scl_q & ~sda_q & sda;
  assign rise_ev  = scl & ~scl_q;
  assign ninth    = rise_ev & (bitn == 4'h8);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      wr_frame  <= 1'b0;
      addr_done <= 1'b0;
      bitn      <= 4'h0;
      shreg     <= 8'h00;
      lo_cnt    <= 16'h0000;
    end else begin
      scl_q  <= scl;
      sda_q  <= sda;
      lo_cnt <= scl ? 16'h0000 : lo_cnt + 16'h0001;
      if (start_ev) begin
        bitn      <= 4'h0;
        addr_done <= 1'b0;
      end else if (rise_ev) begin
        shreg <= {shreg[6:0], sda};
        bitn  <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
        if (bitn == 4'h8) begin
          addr_done <= 1'b1;
        end
        if (!addr_done && bitn == 4'h7) begin
          wr_frame <= ~sda;
        end
      end
    end
  end

  ////////////////////////////////////////
  // properties
  sequence s_ninth_rd;
    ninth && addr_done && !wr_frame;
  endsequence
  sequence s_nack_bit;
    s_ninth_rd ##0 sda;
  endsequence

  property p_sda_stable;
    @(posedge link_clk) disable iff (!nrst) scl [*4] |-> $stable(t_sda_oe);
  endproperty
  property p_addr_ack;
    @(posedge clk) disable iff (!nrst) (ninth && !addr_done) |-> (sda == (shreg[7:1] != BUS_ID));
  endproperty
  property p_wr_ack;
    @(posedge clk) disable iff (!nrst) (ninth && addr_done && wr_frame) |-> (t_sda_oe && !sda);
  endproperty
  property p_addr_quiet;
    @(posedge clk) disable iff (!nrst) (rise_ev && !addr_done && bitn < 4'h8) |-> !t_sda_oe;
  endproperty
  property p_stop_quiet;
    @(posedge clk) disable iff (!nrst) stop_ev |-> ##1 (!t_sda_oe) [*8];
  endproperty
  property p_rd_release;
    @(posedge clk) disable iff (!nrst) s_ninth_rd |-> !t_sda_oe;
  endproperty
  property p_nack_release;
    @(posedge clk) disable iff (!nrst) s_nack_bit |-> ##30 (!t_sda_oe) [*8];
  endproperty
  property p_scl_low;
    @(posedge clk) disable iff (!nrst) rise_ev |-> (lo_cnt >= LOW_CYC - 1);
  endproperty

  a_sda_stable: assert property (p_sda_stable)
    else $error("target sda changed while scl high");
  a_addr_ack: assert property (p_addr_ack)
    else $error("address acknowledge wrong");
  a_wr_ack: assert property (p_wr_ack)
    else $error("written byte not acknowledged");
  a_addr_quiet: assert property (p_addr_quiet)
    else $error("target drove sda in address phase");
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("target drove sda after stop");
  a_rd_release: assert property (p_rd_release)
    else $error("target drove sda in master ack bit");
  a_nack_release: assert property (p_nack_release)
    else $error("target kept sda after master nack");
  a_scl_low: assert property (p_scl_low)
    else $error("scl low period too short");
endmodule

// file: tb/tb_i2c_config_register_port.sv
`timescale 1ns/1ps
module tb_i2c_config_register_port
  import i2c_cfg_pkg::*;
;
  localparam int LOW = 16;
  logic       clk = 0, link_clk = 0, nrst = 0, cmd_valid = 0, cmd_valid_x = 0;
  op_e        cmd_op = op_write;
  logic [7:0] cmd_reg = 0, wdata = 0, cfg_addr = 0, rsp_data, cfg_data, cfg_data_x;
  logic [3:0] cmd_len_m1 = 0;
  logic       wdata_take, wdata_take_x, rsp_valid, done, done_x, nack, nack_x, busy_x;
  logic       busy, cmd_ready;
  logic       oe_x_seen = 0, busy_seen = 0;
  int         err_count = 0, num_checks = 0;
  logic [7:0] wq[$], rq[$];

  i2c_link_if i2c_link_if_i ();
  i2c_link_if i2c_link_if_x_i ();
  i2c_cfg_master #(.LOW_CYC(LOW), .HIGH_CYC(LOW)) i2c_cfg_master_i (.clk(clk), .nrst(nrst),
    .link(i2c_link_if_i), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_reg(cmd_reg), .cmd_len_m1(cmd_len_m1), .wdata(wdata), .wdata_take(wdata_take),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .done(done), .nack(nack));
  i2c_cfg_master #(.BUS_ID(7'h12), .LOW_CYC(LOW), .HIGH_CYC(LOW)) i2c_cfg_master_x_i (
    .clk(clk), .nrst(nrst), .link(i2c_link_if_x_i), .cmd_valid(cmd_valid_x), .cmd_ready(),
    .cmd_op(cmd_op), .cmd_reg(cmd_reg), .cmd_len_m1(cmd_len_m1), .wdata(wdata),
    .wdata_take(wdata_take_x), .rsp_valid(), .rsp_data(), .done(done_x), .nack(nack_x));
  i2c_cfg_target i2c_cfg_target_i (.link_clk(link_clk), .nrst(nrst), .link(i2c_link_if_i),
    .cfg_addr(cfg_addr), .cfg_data(cfg_data), .busy(busy));
  i2c_cfg_target i2c_cfg_target_x_i (.link_clk(link_clk), .nrst(nrst),
    .link(i2c_link_if_x_i), .cfg_addr(cfg_addr), .cfg_data(cfg_data_x), .busy(busy_x));
  i2c_cfg_link_asserts #(.LOW_CYC(LOW)) i2c_cfg_link_asserts_i (.clk(clk),
    .link_clk(link_clk), .nrst(nrst), .scl(i2c_link_if_i.scl), .sda(i2c_link_if_i.sda),
    .t_sda_oe(i2c_link_if_i.t_sda_oe));

  always #2.5 clk = ~clk;
  initial begin
    #1.7;
    forever #6 link_clk = ~link_clk;
  end
  always @(posedge link_clk) begin
    if (i2c_link_if_x_i.t_sda_oe === 1'b1 || (busy_x === 1'b1 && nack_x === 1'b1)) begin
      oe_x_seen <= 1'b1;
    end
    if (busy === 1'b1) busy_seen <= 1'b1;
  end

  ////////////////////////////////////////
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task run(input logic x, input op_e op, input logic [7:0] rg, input logic [3:0] lm1);
    int   idx;
    int   n;
    logic fin;
    idx = 0;
    fin = 0;
    rq.delete();
    @(posedge clk);
    cmd_op <= op;
    cmd_reg <= rg;
    cmd_len_m1 <= lm1;
    wdata <= (wq.size() > 0) ? wq[0] : 8'h00;
    if (x) cmd_valid_x <= 1'b1;
    else cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd_valid_x <= 1'b0;
    for (n = 0; n < 20000 && !fin; n++) begin
      @(negedge clk);
      if ((x ? wdata_take_x : wdata_take) === 1'b1) idx++;
      if (!x && rsp_valid === 1'b1) rq.push_back(rsp_data);
      fin = ((x ? done_x : done) === 1'b1);
      @(posedge clk);
      if (idx < wq.size()) wdata <= wq[idx];
    end
    if (!fin) begin
      check("done_wait", 8'h00, 8'h01);
      results();
    end
  endtask

  task mem(input logic [7:0] a, input logic [7:0] exp, input logic x);
    @(posedge link_clk);
    cfg_addr <= a;
    repeat (3) @(posedge link_clk);
    @(negedge clk);
    check("cfg_data", x ? cfg_data_x : cfg_data, exp);
  endtask

  ////////////////////////////////////////
  task t_defaults();
    for (int a = 0; a < 256; a++) mem(a[7:0], MEM_DEFAULT, 1'b0);
  endtask

  task t_single();
    wq = '{8'ha5};
    run(1'b0, op_write, 8'h10, 4'h0);
    check("nack", {7'h0, nack}, 8'h00);
    check("scl_idle", {7'h0, i2c_link_if_i.scl}, 8'h01);
    check("sda_idle", {7'h0, i2c_link_if_i.sda}, 8'h01);
    check("cmd_ready", {7'h0, cmd_ready}, 8'h01);
    check("busy_seen", {7'h0, busy_seen}, 8'h01);
    check("busy_end", {7'h0, busy}, 8'h00);
    mem(8'h10, 8'ha5, 1'b0);
  endtask

  task t_multi();
    wq = '{8'h11, 8'h22, 8'h33, 8'h44};
    run(1'b0, op_write, 8'hff, 4'h3);
    check("nack", {7'h0, nack}, 8'h00);
    for (int i = 0; i < 4; i++) mem(8'hff + i[7:0], wq[i], 1'b0);
  endtask

  task t_rand();
    logic [7:0] e [3];
    e = '{MEM_DEFAULT, 8'h11, 8'h22};
    run(1'b0, op_rd_rand, 8'hfe, 4'h2);
    check("rd_count", 8'(rq.size()), 8'h03);
    for (int i = 0; i < 3; i++) check("rd_data", rq[i], e[i]);
    mem(8'hfe, MEM_DEFAULT, 1'b0);
  endtask

  task t_cur();
    run(1'b0, op_rd_cur, 8'h00, 4'h1);
    check("cur_count", 8'(rq.size()), 8'h02);
    check("cur_data0", rq[0], 8'h33);
    check("cur_data1", rq[1], 8'h44);
  endtask

  task t_foreign();
    wq = '{8'h5a};
    run(1'b1, op_write, 8'h10, 4'h0);
    check("nack_x", {7'h0, nack_x}, 8'h01);
    check("oe_x_seen", {7'h0, oe_x_seen}, 8'h00);
    check("busy_x_end", {7'h0, busy_x}, 8'h00);
    mem(8'h10, MEM_DEFAULT, 1'b1);
  endtask

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (20) @(posedge clk);
    t_defaults();
    t_single();
    t_multi();
    t_rand();
    t_cur();
    t_foreign();
    results();
  end
endmodule
